// ==== design/ddr3_cmd_host.sv ====
// dram command host: bank tracking, command timing, refresh posting and write data path
// Behaviour
// [R1] device runs long calibration and updates driver and termination impedance
// [R2] host waits init or operational long-calibration window before next command
// [R3] short calibration completes within its window of 64 clocks
// [R4] activate opens given row in selected bank until precharged
// [R5] host precharges a bank before activating another row there
// [R6] read takes starting column from low address bits
// [R7] read with A10 high auto-precharges at burst end
// [R8] A12 picks chop 4 or length 8 when on-the-fly enabled
// [R9] a started burst always runs to completion
// [R10] read pins: cs low, ras high, cas low, we high, cke held high
// [R11] write pins: cs low, ras high, cas low, we low, cke held high
// [R12] write bursts to open row; A10 auto-precharge, A12 chop
// [R13] mask low stores a byte, mask high leaves it unchanged
// [R14] precharge with A10 high closes all banks, otherwise one bank
// [R15] host waits precharge time before touching a precharged bank
// [R16] host activates an idle bank before read or write to it
// [R17] precharge to idle or precharging bank acts as nop; here a precharging bank restarts its precharge time
// [R18] refresh ignores address; each refresh needs its own command
// [R19] host refreshes every 7.8us average, 3.9us when hot
// [R20] after refresh host sends only nop or deselect for refresh time
// [R21] host postpones at most eight refreshes; the count here runs on to 15 and only flags refresh_overdue from eight
// [R22] beyond eight postponed only if all refreshes fit the period
// [R23] burst mode and on-the-fly enable come from mode register zero
// [R24] nop never disturbs an operation in progress
// [R25] per-bank state idle, active with row, precharging is tracked
`timescale 1ns/1ps
`default_nettype none
module ddr3_cmd_host
	import ddr3_host_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	input  wire logic                        ce,
	input  wire logic                        hot,
	input  wire logic                        otf_enable,
	input  wire logic                        init_done,
	input  wire logic                        req_valid,
	output logic                             req_ready,
	input  wire logic [2:0]                  req_op,
	input  wire logic [ddr3_host_pkg::BANK_W-1:0] req_bank,
	input  wire logic [ddr3_host_pkg::ROW_W-1:0]  req_row,
	input  wire logic [ddr3_host_pkg::COL_W-1:0]  req_col,
	input  wire logic                        req_auto_pre,
	input  wire logic                        req_chop,
	output logic                             req_error,
	input  wire logic                        wdata_valid,
	output logic                             wdata_ready,
	input  wire logic [ddr3_host_pkg::DQ_W-1:0]   wdata,
	input  wire logic                        wmask,
	output logic                             cke,
	output logic                             cs_n,
	output logic                             ras_n,
	output logic                             cas_n,
	output logic                             we_n,
	output logic [ddr3_host_pkg::BANK_W-1:0]      ba,
	output logic [ddr3_host_pkg::ADDR_W-1:0]      addr,
	output logic [ddr3_host_pkg::DQ_W-1:0]        dq_out,
	output logic                             dq_oe,
	output logic                             dm,
	output logic [3:0]                       posted_refreshes,
	output logic                             refresh_overdue
);
	import ddr3_host_pkg::*;

	bank_e                  bank_state [BANKS];
	logic [ROW_W-1:0]       bank_row   [BANKS];
	logic [TIMER_W-1:0]     bank_timer [BANKS];
	logic [TIMER_W-1:0]     cmd_timer;
	logic [REFCNT_W-1:0]    refi_count;
	logic                   zq_first;
	logic [3:0]             wr_beats;
	logic [3:0]             wr_delay;
	logic                   issue;
	logic                   legal;
	logic [3:0]             pins;
	logic                   wb_valid;
	logic [DQ_W:0]          wb_data;
	logic                   wb_pop;

	function automatic logic [TIMER_W-1:0] cyc(input int n);
		cyc = TIMER_W'(n);
	endfunction : cyc

	// legality against tracked bank state
	always_comb begin
		unique case (req_op)
			// [R5] [R16] open-row checks
			OP_ACT:   legal = bank_state[req_bank] == BANK_IDLE && bank_timer[req_bank] == '0;
			OP_READ:  legal = bank_state[req_bank] == BANK_ACTIVE && bank_timer[req_bank] == '0;
			OP_WRITE: legal = bank_state[req_bank] == BANK_ACTIVE && bank_timer[req_bank] == '0
				&& wr_beats == 4'h0;
			default:  legal = 1'b1;
		endcase
	end

	// [R2] [R20] command spacing
	assign req_ready = ce && cmd_timer == '0 && wr_beats == 4'h0 && wr_delay == 4'h0;
	assign issue = req_valid && req_ready && legal;
	assign pins = pin_code(req_op);

	// [R10] [R11] command pins, cke low in reset and high after it; nop otherwise
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cke <= 1'b0;
			{cs_n, ras_n, cas_n, we_n} <= 4'hF;
			ba <= '0;
			addr <= '0;
			req_error <= 1'b0;
		end else if (ce) begin
			cke <= 1'b1;
			req_error <= req_valid && req_ready && !legal;
			// [R24] nop between commands
			{cs_n, ras_n, cas_n, we_n} <= issue ? pins : 4'h7;
			ba <= req_bank;
			addr <= '0;
			if (issue) begin
				unique case (req_op)
					// [R4] row address
					OP_ACT: addr <= req_row;
					OP_READ, OP_WRITE: begin
						// [R6] [R7] [R8] [R12] column, auto precharge, chop
						addr[COL_W-1:0] <= req_col;
						addr[A10_POS] <= req_auto_pre;
						addr[A12_POS] <= otf_enable ? !req_chop : 1'b1;
					end
					// [R14] all-bank precharge; A10 also marks long calibration
					OP_PREALL, OP_ZQL: addr[A10_POS] <= 1'b1;
					default: addr <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cmd_timer <= '0;
			zq_first <= 1'b1;
		end else if (ce) begin
			if (issue) begin
				unique case (req_op)
					OP_ZQL: cmd_timer <= zq_first && !init_done ? cyc(T_ZQINIT_CYC)
						: cyc(T_ZQOPER_CYC);
					// [R3] short window
					OP_ZQS: cmd_timer <= cyc(T_ZQCS_CYC);
					// [R20] refresh cycle time
					OP_REF: cmd_timer <= cyc(T_RFC_CYC);
					default: cmd_timer <= '0;
				endcase
				if (req_op == OP_ZQL)
					zq_first <= 1'b0;
			end else if (cmd_timer != '0)
				cmd_timer <= cmd_timer - 1'b1;
		end
	end

	// [R25] per-bank state machine
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int b = 0; b < BANKS; b++) begin
				bank_state[b] <= BANK_IDLE;
				bank_row[b] <= '0;
				bank_timer[b] <= '0;
			end
		end else if (ce) begin
			for (int b = 0; b < BANKS; b++) begin
				if (bank_timer[b] != '0)
					bank_timer[b] <= bank_timer[b] - 1'b1;
				else if (bank_state[b] == BANK_PRECHARGING)
					bank_state[b] <= BANK_IDLE;
				if (issue && (req_bank == 3'(b) || req_op == OP_PREALL)) begin
					unique case (req_op)
						OP_ACT: begin
							bank_state[b] <= BANK_ACTIVE;
							bank_row[b] <= req_row;
							bank_timer[b] <= cyc(T_RCD_CYC);
						end
						OP_READ, OP_WRITE:
							// [R7] [R9] auto precharge after the burst
							if (req_auto_pre) begin
								bank_state[b] <= BANK_PRECHARGING;
								bank_timer[b] <= cyc(T_RP_CYC + CL_CYC + BURST_BEATS);
							end
						// [R15] [R17] timed from the last precharge
						OP_PRE, OP_PREALL:
							if (bank_state[b] != BANK_IDLE) begin
								bank_state[b] <= BANK_PRECHARGING;
								bank_timer[b] <= cyc(T_RP_CYC);
							end
						default: ;
					endcase
				end
			end
		end
	end

	// [R19] [R21] [R22] refresh debt, overdue from eight posted
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			refi_count <= '0;
			posted_refreshes <= 4'h0;
		end else if (ce) begin
			if (refi_count >= REFCNT_W'((hot ? T_REFI_HOT_CYC : T_REFI_CYC) - 1)) begin
				refi_count <= '0;
				// saturate so long neglect never wraps back to no debt
				if (!(issue && req_op == OP_REF) && posted_refreshes != 4'hF)
					posted_refreshes <= posted_refreshes + 4'h1;
			end else begin
				refi_count <= refi_count + 1'b1;
				if (issue && req_op == OP_REF && posted_refreshes != 4'h0)
					posted_refreshes <= posted_refreshes - 4'h1;
			end
		end
	end
	assign refresh_overdue = posted_refreshes >= 4'(MAX_POSTED);

	// [R9] [R12] write data beats launched after write latency
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_delay <= 4'h0;
			wr_beats <= 4'h0;
		end else if (ce) begin
			if (issue && req_op == OP_WRITE) begin
				wr_delay <= 4'(CWL_CYC);
				wr_beats <= (otf_enable && req_chop) ? 4'(CHOP_BEATS) : 4'(BURST_BEATS);
			end else if (wr_delay != 4'h0)
				wr_delay <= wr_delay - 4'h1;
			else if (wr_beats != 4'h0)
				wr_beats <= wr_beats - 4'h1;
		end
	end

	assign wb_pop = wr_delay == 4'h0 && wr_beats != 4'h0;

	ddr3_beat_buffer #(.W(DQ_W + 1)) u_buf (
		.clk       (clk),
		.reset_n   (reset_n),
		.ce        (ce),
		.in_valid  (wdata_valid),
		.in_ready  (wdata_ready),
		.in_data   ({wmask, wdata}),
		.out_valid (wb_valid),
		.out_ready (wb_pop),
		.out_data  (wb_data)
	);

	// [R13] missing beat goes out masked so no byte is corrupted
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dq_out <= '0;
			dm <= 1'b1;
			dq_oe <= 1'b0;
		end else if (ce) begin
			dq_oe <= wb_pop;
			dq_out <= wb_data[DQ_W-1:0];
			dm <= !(wb_pop && wb_valid) || wb_data[DQ_W];
		end
	end

	property p_act_after_idle;
		@(posedge clk) disable iff (!reset_n)
		issue && req_op == OP_ACT |-> bank_state[req_bank] == BANK_IDLE;
	endproperty
	a_act_after_idle: assert property (p_act_after_idle) // [R5]
		else $error("activate to open bank");
	property p_read_pins;
		@(posedge clk) disable iff (!reset_n)
		ce && issue && req_op == OP_READ |=> {cs_n, ras_n, cas_n, we_n} == 4'h5 && cke;
	endproperty
	a_read_pins: assert property (p_read_pins) // [R10]
		else $error("read pins wrong");
	property p_write_pins;
		@(posedge clk) disable iff (!reset_n)
		ce && issue && req_op == OP_WRITE |=> {cs_n, ras_n, cas_n, we_n} == 4'h4;
	endproperty
	a_write_pins: assert property (p_write_pins) // [R11]
		else $error("write pins wrong");
	property p_ref_quiet;
		@(posedge clk) disable iff (!reset_n)
		ce && issue && req_op == OP_REF |=> !issue [*8];
	endproperty
	a_ref_quiet: assert property (p_ref_quiet) // [R20]
		else $error("command during refresh time");
	property p_rw_open;
		@(posedge clk) disable iff (!reset_n)
		issue && (req_op == OP_READ || req_op == OP_WRITE) |-> bank_state[req_bank] == BANK_ACTIVE;
	endproperty
	a_rw_open: assert property (p_rw_open) // [R16]
		else $error("access to closed bank");
	property p_preall_a10;
		@(posedge clk) disable iff (!reset_n)
		ce && issue && req_op == OP_PREALL |=> addr[A10_POS];
	endproperty
	a_preall_a10: assert property (p_preall_a10) // [R14]
		else $error("precharge all without A10");
	property p_chop_a12;
		@(posedge clk) disable iff (!reset_n)
		ce && issue && req_op == OP_READ && otf_enable |=> addr[A12_POS] == !$past(req_chop);
	endproperty
	a_chop_a12: assert property (p_chop_a12) // [R8]
		else $error("A12 does not follow chop");
	property p_write_chop_a12;
		@(posedge clk) disable iff (!reset_n)
		ce && issue && req_op == OP_WRITE && otf_enable |=> addr[A12_POS] == !$past(req_chop);
	endproperty
	a_write_chop_a12: assert property (p_write_chop_a12) // [R12]
		else $error("write A12 does not follow chop");
	property p_posted_limit;
		@(posedge clk) disable iff (!reset_n)
		posted_refreshes <= 4'(MAX_POSTED + 1) && (refresh_overdue == (posted_refreshes >= 4'h8));
	endproperty
	a_posted_limit: assert property (p_posted_limit) // [R21]
		else $error("posted refresh count out of range");
	property p_pre_idle_nop;
		@(posedge clk) disable iff (!reset_n)
		ce && issue && req_op == OP_PRE && bank_state[req_bank] == BANK_IDLE
		|=> bank_state[$past(req_bank)] == BANK_IDLE;
	endproperty
	a_pre_idle_nop: assert property (p_pre_idle_nop) // [R17]
		else $error("precharge to idle bank changed state");
	c_write: cover property (@(posedge clk) issue && req_op == OP_WRITE);
	c_read_ap: cover property (@(posedge clk) issue && req_op == OP_READ && req_auto_pre);
	c_refresh: cover property (@(posedge clk) issue && req_op == OP_REF);
	c_stall: cover property (@(posedge clk) wdata_valid && !wdata_ready);
endmodule : ddr3_cmd_host
`default_nettype wire

// ==== design/ddr3_host_pkg.sv ====
// package: command codes, pin widths and timing constants for the dram command host
package ddr3_host_pkg;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int BANK_W = 3;
	localparam int ROW_W = 16;
	localparam int COL_W = 10;
	localparam int DQ_W = 8;
	localparam int BANKS = 8;
	localparam int BURST_BEATS = 8;
	localparam int CHOP_BEATS = 4;
	localparam int ADDR_W = 16;
	localparam int A10_POS = 10;
	localparam int A12_POS = 12;
	// timing in picoseconds as printed, calibration windows and latencies in clocks
	localparam int T_ZQINIT_CYC = 512;
	localparam int T_ZQOPER_CYC = 256;
	localparam int T_ZQCS_CYC = 64;
	localparam int T_RCD_PS = 13750;
	localparam int T_RP_PS = 13750;
	localparam int T_RFC_PS = 260000;
	localparam int T_REFI_PS = 7800000;
	localparam int T_REFI_HOT_PS = 3900000;
	localparam int T_RCD_CYC = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int T_RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int T_RFC_CYC = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int T_REFI_CYC = T_REFI_PS / CLK_PERIOD_PS;
	localparam int T_REFI_HOT_CYC = T_REFI_HOT_PS / CLK_PERIOD_PS;
	localparam int MAX_POSTED = 8;
	localparam int CL_CYC = 6;
	localparam int CWL_CYC = 5;
	localparam int TIMER_W = 11;
	localparam int REFCNT_W = 10;
	localparam logic [2:0] OP_ACT = 3'h0;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam logic [2:0] OP_PRE = 3'h3;
	localparam logic [2:0] OP_PREALL = 3'h4;
	localparam logic [2:0] OP_ZQL = 3'h5;
	localparam logic [2:0] OP_ZQS = 3'h6;
	localparam logic [2:0] OP_REF = 3'h7;
	typedef enum logic [1:0] { BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGING } bank_e;
	// pins {cs_n, ras_n, cas_n, we_n}
	function automatic logic [3:0] pin_code(input logic [2:0] op);
		unique case (op)
			OP_ACT:    pin_code = 4'h3;
			OP_READ:   pin_code = 4'h5;
			OP_WRITE:  pin_code = 4'h4;
			OP_PRE:    pin_code = 4'h2;
			OP_PREALL: pin_code = 4'h2;
			OP_ZQL:    pin_code = 4'h6;
			OP_ZQS:    pin_code = 4'h6;
			OP_REF:    pin_code = 4'h1;
		endcase
	endfunction : pin_code
endpackage : ddr3_host_pkg

// ==== design/ddr3_beat_buffer.sv ====
// two-entry valid/ready buffer carrying data beats
`timescale 1ns/1ps
`default_nettype none
module ddr3_beat_buffer #(
	parameter int W = 9
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         ce,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem [2];
	logic         wr_ptr;
	logic         rd_ptr;
	logic [1:0]   count;
	logic         push;
	logic         pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// read side is registered so data outputs come from flip-flops
	always_ff @(posedge clk) begin
		if (!reset_n)
			out_data <= '0;
		else if (ce)
			out_data <= (pop || !out_valid) ? (push && (count == 2'h0 || (pop && count == 2'h1))
				? in_data : mem[pop ? ~rd_ptr : rd_ptr]) : out_data;
	end
endmodule : ddr3_beat_buffer
`default_nettype wire

// ==== tb/ddr3_device_model.sv ====
// behavioural dram device: decodes command pins, tracks banks, counts stored beats
`timescale 1ns/1ps
`default_nettype none
module ddr3_device_model
	import ddr3_host_pkg::*;
(
	input  wire logic                             clk,
	input  wire logic                             otf_enable,
	input  wire logic                             init_done,
	input  wire logic                             cke,
	input  wire logic                             cs_n,
	input  wire logic                             ras_n,
	input  wire logic                             cas_n,
	input  wire logic                             we_n,
	input  wire logic [ddr3_host_pkg::BANK_W-1:0] ba,
	input  wire logic [ddr3_host_pkg::ADDR_W-1:0] addr,
	input  wire logic [ddr3_host_pkg::DQ_W-1:0]   dq,
	input  wire logic                             dq_oe,
	input  wire logic                             dm,
	output logic      [7:0]                       act_mask,
	output logic      [7:0]                       viol,
	output logic      [7:0]                       stored,
	output logic      [7:0]                       xsum
);
	import ddr3_host_pkg::*;
	bank_e st[BANKS];
	int    ta[BANKS];
	int    tp[BANKS];
	int    t = 0;
	int    tr = -1000;
	int    tz = 0;
	int    n;
	initial begin
		viol = 8'h00;
		stored = 8'h00;
		xsum = 8'h00;
		act_mask = 8'h00;
		for (int i = 0; i < BANKS; i++) begin
			st[i] = BANK_IDLE;
			tp[i] = -100;
		end
	end
	always @(posedge clk) begin
		t++;
		for (int i = 0; i < BANKS; i++) begin
			if (st[i] == BANK_PRECHARGING && t - tp[i] >= T_RP_CYC) st[i] = BANK_IDLE;
		end
		if (cke && !cs_n && {ras_n, cas_n, we_n} != 3'h7) begin
			if (t - tr < T_RFC_CYC || t < tz) viol++;
			case ({ras_n, cas_n, we_n})
				3'h3: begin
					if (st[ba] != BANK_IDLE) viol++;
					st[ba] = BANK_ACTIVE;
					ta[ba] = t;
				end
				3'h5, 3'h4: begin
					if (st[ba] != BANK_ACTIVE || t - ta[ba] < T_RCD_CYC) viol++;
					n = (otf_enable && !addr[A12_POS]) ? CHOP_BEATS : BURST_BEATS;
					if (addr[A10_POS]) begin
						st[ba] = BANK_PRECHARGING;
						tp[ba] = t + CL_CYC + n;
					end
				end
				3'h2: begin
					// one or all, idle stays idle
					for (int i = 0; i < BANKS; i++) begin
						if ((addr[A10_POS] || ba == i) && st[i] != BANK_IDLE) begin
							st[i] = BANK_PRECHARGING;
							tp[i] = t;
						end
					end
				end
				3'h1: tr = t;
				3'h6: tz = t + (addr[A10_POS] ? (init_done ? T_ZQOPER_CYC : T_ZQINIT_CYC) : T_ZQCS_CYC);
				default: viol++;
			endcase
		end
		// masked beats leave the array alone
		if (dq_oe && !dm) begin
			stored++;
			xsum ^= dq;
		end
		for (int i = 0; i < BANKS; i++) act_mask[i] = (st[i] == BANK_ACTIVE);
	end
endmodule : ddr3_device_model
`default_nettype wire

// ==== tb/ddr3_cmd_host_tb.sv ====
// self-checking bench for the dram command host
`timescale 1ns/1ps
`default_nettype none
module ddr3_cmd_host_tb;
	import ddr3_host_pkg::*;
	logic        clk = 0, reset_n = 0, ce = 1, hot = 0, otf = 0, init_done = 0;
	logic        req_valid = 0, req_auto_pre = 0, req_chop = 0, wdata_valid = 0, wmask = 0;
	logic [2:0]  req_op = 3'h0, req_bank = 3'h0, ba;
	logic [15:0] req_row = 16'h0, addr, sa;
	logic [9:0]  req_col = 10'h0;
	logic [7:0]  wdata = 8'h00, dq_out, act_mask, viol, stored, xsum;
	logic [3:0]  posted_refreshes, pins;
	logic        req_ready, req_error, wdata_ready, cke, cs_n, ras_n, cas_n, we_n;
	logic        dq_oe, dm, refresh_overdue, err;
	int          n_mismatch = 0, n_compared = 0, cycles = 0;
	ddr3_cmd_host u_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .hot(hot), .otf_enable(otf),
		.init_done(init_done), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_auto_pre(req_auto_pre),
		.req_chop(req_chop), .req_error(req_error), .wdata_valid(wdata_valid),
		.wdata_ready(wdata_ready), .wdata(wdata), .wmask(wmask), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_out(dq_out),
		.dq_oe(dq_oe), .dm(dm), .posted_refreshes(posted_refreshes),
		.refresh_overdue(refresh_overdue));
	ddr3_device_model u_dev (.clk(clk), .otf_enable(otf), .init_done(init_done), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
		.dq(dq_out), .dq_oe(dq_oe), .dm(dm), .act_mask(act_mask), .viol(viol),
		.stored(stored), .xsum(xsum));
	always #4 clk = ~clk;
	// ceiling well above the refresh wait of about ten intervals
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	// gap first so valid is never lowered and raised in one step
	task automatic send(input logic [2:0] op, input logic [2:0] bk, input logic [15:0] row,
			input logic [9:0] col, input logic ap, input logic chop);
		int i;
		i = 0;
		tick(1);
		{req_op, req_bank, req_row, req_col, req_auto_pre, req_chop} = {op, bk, row, col, ap, chop};
		req_valid = 1;
		while (req_ready !== 1'b1 && i < 2000) begin
			tick(1);
			i++;
		end
		tick(1);
		req_valid = 0;
		pins = {cs_n, ras_n, cas_n, we_n};
		err = req_error;
		sa = addr;
	endtask : send
	task automatic push(input int from, input int cnt);
		int i;
		for (int k = from; k < from + cnt; k++) begin
			i = 0;
			wdata = 8'hA0 + k[7:0];
			wmask = (k == 1 || k == 5);
			wdata_valid = 1;
			while (wdata_ready !== 1'b1 && i < 2000) begin
				tick(1);
				i++;
			end
			tick(1);
		end
		wdata_valid = 0;
	endtask : push
	task automatic t_read();
		send(OP_ACT, 3'h3, 16'h1234, 10'h0, 0, 0);
		chk("act pins", 4'h3, pins);
		chk("act row", 16'h1234, addr);
		tick(2);
		chk("bank open", 8'h08, act_mask);
		for (int k = 0; k < 3; k++) begin
			otf = (k != 0);
			send(OP_READ, 3'h3, 16'h0, 10'h2D5 + k[9:0], k == 2, k != 2);
			chk("read pins", 4'h5, pins);
			chk("read bank", 3'h3, ba);
			chk("read col", 10'h2D5 + k[9:0], addr[9:0]);
			chk_bit("read chop", !(otf && k != 2), addr[A12_POS]);
			chk_bit("read auto pre", k == 2, addr[A10_POS]);
		end
		tick(24);
		chk("auto pre closed", 8'h00, act_mask);
		otf = 0;
	endtask : t_read
	task automatic t_refuse();
		send(OP_READ, 3'h5, 16'h0, 10'h0, 0, 0);
		chk_bit("read idle refused", 1, err);
		chk("read idle pins", 4'h7, pins);
		send(OP_ACT, 3'h5, 16'h0042, 10'h0, 0, 0);
		tick(2);
		send(OP_ACT, 3'h5, 16'h0043, 10'h0, 0, 0);
		chk_bit("act open refused", 1, err);
		send(OP_PRE, 3'h5, 16'h0, 10'h0, 0, 0);
		chk("pre pins", 4'h2, pins);
		chk("pre bank", 3'h5, ba);
		chk_bit("pre one bank", 0, addr[A10_POS]);
		send(OP_PRE, 3'h5, 16'h0, 10'h0, 0, 0);
		chk_bit("pre again taken", 0, err);
		send(OP_PRE, 3'h6, 16'h0, 10'h0, 0, 0);
		chk_bit("pre idle taken", 0, err);
		chk("pre idle pins", 4'h2, pins);
		tick(4);
		chk("bank closed", 8'h00, act_mask);
	endtask : t_refuse
	task automatic t_write();
		logic [7:0] e;
		e = 8'h00;
		send(OP_ACT, 3'h1, 16'h0777, 10'h0, 0, 0);
		tick(2);
		push(0, 2);
		chk_bit("buffer full", 0, wdata_ready);
		fork
			begin
				tick(1);
				push(2, 6);
			end
			send(OP_WRITE, 3'h1, 16'h0, 10'h008, 0, 0);
		join
		chk("write pins", 4'h4, pins);
		chk_bit("write auto pre", 0, sa[A10_POS]);
		tick(30);
		for (int k = 0; k < 8; k++) begin
			if (k != 1 && k != 5) e ^= 8'hA0 + k[7:0];
		end
		chk("stored beats", 16'd6, stored);
		chk("stored data", e, xsum);
		otf = 1;
		fork
			push(8, 4);
			send(OP_WRITE, 3'h1, 16'h0, 10'h010, 0, 1);
		join
		chk_bit("write chop", 0, sa[A12_POS]);
		tick(30);
		e ^= 8'hA8 ^ 8'hA9 ^ 8'hAA ^ 8'hAB;
		chk("chop beats", 16'd10, stored);
		chk("chop data", e, xsum);
		otf = 0;
		send(OP_PREALL, 3'h0, 16'h0, 10'h0, 0, 0);
		chk_bit("pre all", 1, addr[A10_POS]);
		tick(4);
		chk("all closed", 8'h00, act_mask);
	endtask : t_write
	task automatic zq(input logic [2:0] op, input logic a10, input int win);
		int i;
		i = 0;
		send(op, 3'h0, 16'h0, 10'h0, 0, 0);
		chk("zq pins", 4'h6, pins);
		chk_bit("zq length", a10, addr[A10_POS]);
		while (req_ready !== 1'b1 && i < 1000) begin
			tick(1);
			i++;
		end
		chk("zq window", win, i);
	endtask : zq
	task automatic t_refresh();
		logic [3:0] p;
		int         i;
		i = 0;
		p = posted_refreshes;
		// line up with an interval boundary so each wait spans exactly one
		while (posted_refreshes === p && i < 1000) begin
			tick(1);
			i++;
		end
		i = 0;
		p = posted_refreshes;
		tick(T_REFI_CYC);
		chk("posted one more", p + 4'h1, posted_refreshes);
		send(OP_REF, 3'h0, 16'h0, 10'h0, 0, 0);
		chk("refresh pins", 4'h1, pins);
		while (req_ready !== 1'b1 && i < 1000) begin
			tick(1);
			i++;
		end
		chk("refresh quiet", T_RFC_CYC, i);
		chk("posted paid", p, posted_refreshes);
		i = 0;
		while (refresh_overdue !== 1'b1 && i < 12000) begin
			tick(1);
			i++;
		end
		chk("posted limit", MAX_POSTED, posted_refreshes);
		send(OP_REF, 3'h0, 16'h0, 10'h0, 0, 0);
		chk("overdue paid", MAX_POSTED - 1, posted_refreshes);
		hot = 1;
		p = posted_refreshes;
		tick(T_REFI_HOT_CYC);
		chk("hot interval", p + 4'h1, posted_refreshes);
	endtask : t_refresh
	initial begin
		tick(1);
		chk_bit("cke in reset", 0, cke);
		chk("pins in reset", 4'hF, {cs_n, ras_n, cas_n, we_n});
		chk_bit("mask in reset", 1, dm);
		tick(1);
		reset_n = 1;
		tick(2);
		chk_bit("cke after reset", 1, cke);
		zq(OP_ZQL, 1, T_ZQINIT_CYC);
		init_done = 1;
		zq(OP_ZQL, 1, T_ZQOPER_CYC);
		zq(OP_ZQS, 0, T_ZQCS_CYC);
		t_read();
		t_refuse();
		t_write();
		t_refresh();
		chk("device faults", 16'd0, viol);
		complete_run();
	end
endmodule : ddr3_cmd_host_tb
`default_nettype wire
